// ==== hw/ods_pkg.sv ====
// Shared constants for the octal driver serial control block
package ods_pkg;
    localparam int CH_N = 8;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [2:0] SO_LAST_STATUS = 3'h7;
    localparam logic [2:0] SO_FIRST_IDX = 3'h6;
    localparam logic [7:0] CH_ALL_OFF = 8'h00;
    localparam logic [7:0] WORD_ZERO = 8'h00;
    // Synchroniser vector layout
    localparam int SYNC_W = 27;
    localparam int POS_OC = 0;
    localparam int POS_OT = 8;
    localparam int POS_OL = 16;
    localparam int POS_MODE = 24;
    localparam int POS_UV = 25;
    localparam int POS_CS = 26;
    // Chip select idles high, everything else low
    localparam logic [26:0] SYNC_RST = 27'h400_0000;
    typedef enum logic {ODS_LATCH_OFF, ODS_CUR_LIMIT} ods_fault_type;
endpackage

// ==== hw/ods_ctrl.sv ====
// Serial control, protection and diagnostic logic of the octal low-side driver
//
// How it works
// - Serial input captured on each shift clock falling edge while select is low.
// - Serial output advances on each shift clock rising edge.
// - Select high: clock and input ignored, serial output released.
// - Command bit one turns its output off at chip select rise.
// - Command bit zero turns its output on at chip select rise.
// - Frame is eight bits, output seven first down to output zero.
// - Command word counts as complete after eight bits in one frame.
// - Reset on low reset input or logic supply undervoltage.
// - Latch mode: overcurrent output shut off until next write.
// - Fault response selectable: current limit or shutdown.
// - Thermal shutdown acts per channel independently.
// - Open load checked only on channels commanded off.
// - Cascadable: serial output feeds the next device's serial input.
// - Chip select rise moves the command word to all outputs together.
// - Chip select fall loads drain status for shifting out.
// - Status high for healthy off channel, low for healthy on channel.
// - Serial output shift timing ignores the reset input; reset clears the status and data bits it shifts.
`timescale 1ns/1ns
module ods_ctrl
    import ods_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic fault_latch_mode_select,
    input wire logic uv_detect,
    input wire logic [7:0] oc_detect,
    input wire logic [7:0] ot_detect,
    input wire logic [7:0] open_load_detect,
    output logic [7:0] out_drive,
    output logic [7:0] out_limit,
    output logic [7:0] status_word
);

    // ---------------- Link side, shift clock domain ----------------
    logic [7:0] cap_r;
    logic [3:0] cnt_r;
    logic armed_r;
    logic [3:0] rcnt_r;
    logic so_r;
    logic so_run_r;
    logic [7:0] snap_r;
    wire [2:0] so_idx = SO_FIRST_IDX - rcnt_r[2:0];
    wire so_in_status = rcnt_r < BIT_CNT_FULL - BIT_CNT_ONE;

    // Preset by the frame's own select, so no shift edge is needed to rearm
    always_ff @(negedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            armed_r <= 1'b1;
        end else begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(negedge sclk or negedge rstn) begin
        if (!rstn) begin
            cap_r <= WORD_ZERO;
            cnt_r <= BIT_CNT_ZERO;
        end else if (!chip_select_n) begin
            cap_r <= {cap_r[6:0], serial_in};
            if (armed_r) begin
                cnt_r <= BIT_CNT_ONE;
            end else if (cnt_r != BIT_CNT_FULL) begin
                cnt_r <= cnt_r + BIT_CNT_ONE;
            end
        end
    end

    // No rstn here: the output shift timing follows select and clock only
    always_ff @(posedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            rcnt_r <= BIT_CNT_ZERO;
            so_r <= 1'b0;
            so_run_r <= 1'b0;
        end else begin
            so_run_r <= 1'b1;
            if (rcnt_r != BIT_CNT_FULL) begin
                rcnt_r <= rcnt_r + BIT_CNT_ONE;
            end
            // Status first, then the first bits shifted in for the next device
            // Only seven falls precede the eighth rise, so the oldest bit sits at six
            so_r <= so_in_status ? snap_r[so_idx] : cap_r[6];
        end
    end

    assign serial_out = so_run_r ? so_r : snap_r[SO_LAST_STATUS];
    assign serial_out_oe = !chip_select_n;

    // ---------------- Core side, clk domain ----------------
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] flt_r;
    wire [SYNC_W-1:0] raw_in = {chip_select_n, uv_detect, fault_latch_mode_select,
                                open_load_detect, ot_detect, oc_detect};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_flt
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    flt_r[gi] <= SYNC_RST[gi];
                end else if (s2_r[gi] == s3_r[gi]) begin
                    flt_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate

    wire [7:0] oc_f = flt_r[POS_OC +: CH_N];
    wire [7:0] ot_f = flt_r[POS_OT +: CH_N];
    wire [7:0] ol_f = flt_r[POS_OL +: CH_N];
    wire uv_f = flt_r[POS_UV];
    wire cs_f = flt_r[POS_CS];
    wire ods_fault_type fmode = flt_r[POS_MODE] ? ODS_CUR_LIMIT : ODS_LATCH_OFF;
    wire latch_mode = fmode == ODS_LATCH_OFF;

    logic cs_d_r;
    logic [7:0] on_r;
    logic [7:0] on_nxt;
    logic [7:0] latch_r;
    logic [7:0] latch_nxt;
    logic [7:0] drive_r;
    logic [7:0] limit_r;
    logic [7:0] snap_nxt;

    wire cs_rise = cs_f && !cs_d_r;
    wire cs_fall = !cs_f && cs_d_r;
    // Count and word are quiet after select rises, so reading them here is safe
    wire frame_full = cnt_r == BIT_CNT_FULL;
    wire commit = cs_rise && frame_full;
    wire srst = uv_f;
    wire [7:0] fault = latch_r | ot_f | oc_f;
    // Drain high when off and healthy or on and faulted; open load pulls an off channel low
    wire [7:0] stat = (on_r & fault) | (~on_r & ~ol_f);
    wire [7:0] oc_cut = latch_mode ? oc_f : CH_ALL_OFF;
    wire [7:0] drive_nxt = on_r & ~latch_r & ~ot_f & ~oc_cut;
    wire [7:0] limit_nxt = latch_mode ? CH_ALL_OFF : (on_r & oc_f & ~ot_f);

    always_comb begin
        on_nxt = on_r;
        if (srst) begin
            on_nxt = CH_ALL_OFF;
        end else if (commit) begin
            on_nxt = ~cap_r;
        end
    end

    // A new overcurrent beats the clear of a write in the same cycle
    always_comb begin
        latch_nxt = commit ? CH_ALL_OFF : latch_r;
        if (srst) begin
            latch_nxt = CH_ALL_OFF;
        end else if (latch_mode) begin
            latch_nxt = latch_nxt | (oc_f & on_r);
        end
    end

    // Snapshot held still for the whole frame; the link side reads it as a word
    always_comb begin
        snap_nxt = snap_r;
        if (cs_fall) begin
            snap_nxt = stat;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_d_r <= 1'b1;
            on_r <= CH_ALL_OFF;
            latch_r <= CH_ALL_OFF;
            drive_r <= CH_ALL_OFF;
            limit_r <= CH_ALL_OFF;
            snap_r <= WORD_ZERO;
        end else begin
            cs_d_r <= cs_f;
            on_r <= on_nxt;
            latch_r <= latch_nxt;
            drive_r <= drive_nxt;
            limit_r <= limit_nxt;
            snap_r <= snap_nxt;
        end
    end

    assign out_drive = drive_r;
    assign out_limit = limit_r;
    assign status_word = snap_r;

    // ---------------- Checks ----------------
    a_shift_capture: assert property (
        @(negedge sclk) disable iff (chip_select_n || !rstn)
        1'b1 |=> cap_r[0] == $past(serial_in))
        else $error("serial input bit not captured");

    a_commit_word: assert property (
        @(posedge clk) disable iff (!rstn)
        (commit && !srst) |=> on_r == ~$past(cap_r))
        else $error("command word not applied at select rise");

    a_short_frame: assert property (
        @(posedge clk) disable iff (!rstn)
        (cs_rise && !frame_full && !srst) |=> $stable(on_r))
        else $error("short frame changed outputs");

    a_status_load: assert property (
        @(posedge clk) disable iff (!rstn)
        cs_fall |=> snap_r == $past(stat))
        else $error("drain status not loaded at select fall");

    a_oc_latch: assert property (
        @(posedge clk) disable iff (!rstn)
        (latch_mode && !srst && |(oc_f & on_r)) |=> ##1 ((latch_r & drive_r) == CH_ALL_OFF)
            && ((latch_r & $past(oc_f & on_r, 2)) == $past(oc_f & on_r, 2)))
        else $error("overcurrent channel not latched off");

    a_thermal_off: assert property (
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> (drive_r & $past(ot_f)) == CH_ALL_OFF)
        else $error("hot channel still driven");

    a_open_load: assert property (
        @(posedge clk) disable iff (!rstn)
        cs_fall |=> (snap_r & $past(~on_r & ol_f)) == CH_ALL_OFF
            && (snap_r & $past(on_r)) == $past(on_r & fault))
        else $error("open load reported on wrong channel state");

    a_status_ok: assert property (
        @(posedge clk) disable iff (!rstn)
        cs_fall |=> ((snap_r ^ ~$past(on_r)) & ~$past(fault | ol_f)) == CH_ALL_OFF)
        else $error("healthy channel status wrong");

    a_uv_reset: assert property (
        @(posedge clk) disable iff (!rstn)
        srst |=> on_r == CH_ALL_OFF ##1 drive_r == CH_ALL_OFF)
        else $error("undervoltage did not switch outputs off");

    a_limit_mode: assert property (
        @(posedge clk) disable iff (!rstn)
        (!latch_mode && !srst) |=> out_limit == $past(on_r & oc_f & ~ot_f))
        else $error("limit mode fault handling wrong");

    a_limit_latched: assert property (
        @(posedge clk) disable iff (!rstn)
        latch_mode |=> out_limit == CH_ALL_OFF)
        else $error("current limit flagged in latch mode");

    a_hold_between: assert property (
        @(posedge clk) disable iff (!rstn)
        !(commit || srst) |=> $stable(on_r))
        else $error("command latches changed without a commit");

    a_latch_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        !(commit || srst) |=> (latch_r & $past(latch_r)) == $past(latch_r))
        else $error("overcurrent latch released without a write");

    a_reset_off: assert property (
        @(posedge clk)
        !rstn |-> out_drive == CH_ALL_OFF && out_limit == CH_ALL_OFF)
        else $error("outputs active during reset");

    // Stray shift clocks with select high must leave the word and count alone
    a_idle_ignore: assert property (
        @(negedge sclk) disable iff (!rstn)
        chip_select_n |=> $stable(cap_r) && $stable(cnt_r))
        else $error("shift clock acted while deselected");

    a_first_bit: assert property (
        @(negedge sclk) disable iff (chip_select_n || !rstn)
        armed_r |=> cnt_r == BIT_CNT_ONE)
        else $error("bit count not restarted in new frame");

    a_cascade_out: assert property (
        @(posedge sclk) disable iff (chip_select_n)
        rcnt_r == BIT_CNT_FULL |-> serial_out == $past(serial_in, 8))
        else $error("cascade output not delayed by eight bits");

    a_so_moves: assert property (
        @(posedge clk) disable iff (chip_select_n || !rstn)
        $changed(serial_out) |-> $rose(sclk) || $changed(snap_r))
        else $error("serial output moved off a shift clock rise");

endmodule

// ==== dv/ods_master.sv ====
// Serial bus master model for the command link
`timescale 1ns/1ns
module ods_master (
    output logic sclk,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // Samples the returned stream just before each rise, where it is stable
    task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        chip_select_n = 1'b0;
        #48;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = d[i];
            #8;
            rx = {rx[14:0], serial_out};
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
            #8;
        end
        #8;
        chip_select_n = 1'b1;
        // Released line must not keep its last value
        serial_in = ~serial_in;
    endtask
    // Optional idle clocking with select high; the block must ignore it
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in = ~serial_in;
            #16;
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
        end
    endtask
endmodule

// ==== dv/ods_ctrl_tb.sv ====
// Self-checking bench for the octal driver serial control block
`timescale 1ns/1ns
module ods_ctrl_tb;
    import ods_pkg::*;
    logic clk, rstn, sclk, chip_select_n, serial_in, serial_out, serial_out_oe, mode, uv;
    logic [7:0] oc, ot, ol, out_drive, out_limit, status_word, on_now, lat;
    logic [15:0] rx;
    int bad_count = 0;
    int num_checks = 0;
    ods_ctrl i_ods_ctrl (.clk(clk), .rstn(rstn), .sclk(sclk), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .fault_latch_mode_select(mode), .uv_detect(uv), .oc_detect(oc), .ot_detect(ot),
        .open_load_detect(ol), .out_drive(out_drive), .out_limit(out_limit),
        .status_word(status_word));
    ods_master i_ods_master (.sclk(sclk), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Drain status: on channels read high only when faulted
    function automatic logic [7:0] stat_f();
        return (on_now & (ot | oc | lat)) | (~on_now & ~ol);
    endfunction
    task automatic frame(input logic [7:0] c);
        logic [7:0] st;
        st = stat_f();
        i_ods_master.xfer({8'h00, c}, 8, rx);
        check(rx[7:0], st);
        check(status_word, st);
        cyc(10);
        on_now = ~c;
        lat = on_now & oc & {8{~mode}};
        check(out_drive, on_now & ~ot & ~lat);
    endtask
    initial begin
        rstn = 1'b0;
        mode = 1'b0;
        uv = 1'b0;
        oc = 8'h00;
        ot = 8'h00;
        ol = 8'h00;
        on_now = 8'h00;
        lat = 8'h00;
        rx = 16'h0000;
        void'($urandom(32'h70ad));
        cyc(2);
        rstn = 1'b1;
        cyc(2);
        check(8'(serial_out_oe), 8'h00);
        check(out_drive, CH_ALL_OFF);
        for (int k = 0; k < 8; k++) begin
            ot = 8'($urandom());
            ol = 8'($urandom());
            cyc(6);
            frame(8'($urandom()));
        end
        ot = 8'h00;
        ol = 8'h00;
        cyc(6);
        i_ods_master.xfer(16'h5a00, 16, rx);
        check(rx[7:0], 8'h5a);
        check(rx[15:8], stat_f());
        cyc(10);
        on_now = 8'hff;
        check(out_drive, 8'hff);
        i_ods_master.xfer(16'h001f, 5, rx);
        cyc(10);
        check(out_drive, 8'hff);
        i_ods_master.stray(4);
        cyc(2);
        check(out_drive, 8'hff);
        mode = 1'b1;
        oc = 8'h01;
        cyc(8);
        check(out_limit, 8'h01);
        check(out_drive, 8'hff);
        mode = 1'b0;
        cyc(8);
        check(out_drive, 8'hfe);
        oc = 8'h00;
        lat = 8'h01;
        cyc(8);
        check(out_drive, 8'hfe);
        frame(8'h00);
        uv = 1'b1;
        cyc(8);
        check(out_drive, CH_ALL_OFF);
        uv = 1'b0;
        on_now = 8'h00;
        cyc(8);
        check(out_drive, CH_ALL_OFF);
        frame(8'h0f);
        rstn = 1'b0;
        fork
            i_ods_master.xfer(16'h0000, 8, rx);
            begin
                #30;
                check(8'(serial_out_oe), 8'h01);
            end
        join
        check(rx[7:0], 8'h00);
        cyc(4);
        check(out_drive, CH_ALL_OFF);
        rstn = 1'b1;
        wrap_up();
    end
endmodule
